// *** logic/vepms_ctl.sv ***
// Sequencing controller: drives sleep pin, pixel clock and device registers.
// Assumes software reaches CTRL and STATUS over Avalon-MM on the same clk.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Hold sleep low over 100 ns first.
// - Sleep initialises device into composite mode.
// - Pixel clock runs, datapath bit low 100+ clocks.
// - Device takes writes without pixel clock.
// - Embedded sync: DACs on only after lock.
// - Component mode: 100 clocks, then select 01.
// - PLL bit set after component selected.
// - Datapath bit set after component selected.
// - Wait over 31 ms after PLL before DACs.
// - DAC mode: 100 clocks, then select 10.
// - DAC mode: datapath bit after selecting mode.
// - Clear datapath bit before sleep goes low.
// - Sleep clears registers; rewrite after release.
// - Capture edge selectable by register.
// - Function select picks block; others power down.
// - PLL bit powers PLL; component needs it.
// - DAC channel drives only when enabled.
module vepms_ctl #(
  parameter int REF_CYC  = vepms_pkg::REF_CYC,
  parameter int PLL_CYC  = vepms_pkg::PLL_CYC,
  parameter int PIX_HALF = 1
) (
  input  wire logic        clk,               // System clock.
  input  wire logic        nrst,              // Asynchronous reset, active low.
  vepms_link_if.ctl        link,              // Link to the device.
  input  wire logic [3:0]  avs_address,       // Avalon byte address.
  input  wire logic        avs_read,          // Avalon read.
  input  wire logic        avs_write,         // Avalon write.
  input  wire logic [31:0] avs_writedata,     // Avalon write data.
  output logic [31:0]      avs_readdata,      // Avalon read data.
  output logic             avs_waitrequest    // Avalon wait request.
);
  typedef enum {
    H_IDLE, H_SLP, H_REF, H_CLK, H_WCAP, H_WFMT, H_WPLL, H_WDTR,
    H_WAITPLL, H_LOCK, H_WDAC, H_RUN, H_WDOWN
  } vepms_state_t;

  vepms_state_t state_r;
  logic [31:0]  ctrl_r, limit;
  logic         go_r, down_r, clr_r, tdone, tick, pix_clk_r, clk_run;
  logic         ack, sleep_n_r, wr_r, rd_r, rd_q_r;
  logic [5:0]   addr_r;
  logic [7:0]   wdata_r;
  logic [15:0]  div_r;
  logic [1:0]   mode;

  assign mode = ctrl_r[vepms_pkg::CTL_MODE_LSB +: 2];
  assign ack  = (avs_read || avs_write) && avs_waitrequest;

  // Each access waits one cycle, then completes with waitrequest low.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !ack;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      avs_readdata <= 32'h0000_0000;
    else if (ack && avs_read)
    begin
      if (avs_address == vepms_pkg::AVS_CTRL)
        avs_readdata <= ctrl_r;
      else if (avs_address == vepms_pkg::AVS_STATUS)
      begin
        avs_readdata                      <= 32'h0000_0000;
        avs_readdata[vepms_pkg::ST_RUN]   <= state_r == H_RUN;
        avs_readdata[vepms_pkg::ST_BUSY]  <= state_r != H_RUN && state_r != H_IDLE;
        avs_readdata[vepms_pkg::ST_SLEEP] <= !sleep_n_r;
      end
      else
        avs_readdata <= 32'h0000_0000;
    end
  end

  // Go and down are write-one pulses; the rest of CTRL is stored.
  // A write lands on the edge that completes the access, never earlier.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r <= vepms_pkg::CTRL_RST_VAL;
      go_r   <= 1'b0;
      down_r <= 1'b0;
    end
    else
    begin
      go_r   <= 1'b0;
      down_r <= 1'b0;
      if (!avs_waitrequest && avs_write && avs_address == vepms_pkg::AVS_CTRL)
      begin
        ctrl_r <= avs_writedata & 32'h0000_073C;
        go_r   <= avs_writedata[vepms_pkg::CTL_GO];
        down_r <= avs_writedata[vepms_pkg::CTL_DOWN];
      end
    end
  end

  // Pixel clock divider; tick marks each half period.
  // The pixel clock stays still until the references have settled.
  assign clk_run = state_r != H_IDLE && state_r != H_SLP && state_r != H_REF;
  assign tick    = clk_run && div_r == 16'(PIX_HALF - 1);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_r     <= 16'h0000;
      pix_clk_r <= 1'b0;
    end
    else if (!clk_run)
    begin
      div_r     <= 16'h0000;
      pix_clk_r <= 1'b0;
    end
    else if (tick)
    begin
      div_r     <= 16'h0000;
      pix_clk_r <= !pix_clk_r;
    end
    else
      div_r <= div_r + 16'h0001;
  end

  always_comb
  begin
    limit = 32'h0000_0001;
    case (state_r)
      H_SLP:   limit = 32'(vepms_pkg::SLEEP_CYC);
      H_REF:   limit = 32'(REF_CYC);
      H_CLK:   limit = 32'(vepms_pkg::INIT_PIX_CYC);
      default: limit = 32'(PLL_CYC);
    endcase
  end

  vepms_cnt #(.W(32)) u_wait (
    .clk   (clk),
    .nrst  (nrst),
    .clr   (clr_r),
    .en    (state_r == H_CLK ? (tick && !pix_clk_r) : 1'b1),
    .limit (limit),
    .done  (tdone)
  );

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r   <= H_IDLE;
      clr_r     <= 1'b1;
      sleep_n_r <= 1'b0;
      wr_r      <= 1'b0;
      rd_r      <= 1'b0;
      rd_q_r    <= 1'b0;
      addr_r    <= 6'h00;
      wdata_r   <= 8'h00;
    end
    else
    begin
      clr_r <= 1'b0;
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      rd_q_r <= rd_r;
      case (state_r)
        H_IDLE:
          if (go_r)
          begin
            state_r <= H_SLP;
            clr_r   <= 1'b1;
          end
        H_SLP:
          if (tdone)
          begin
            sleep_n_r <= 1'b1;
            state_r   <= H_REF;
            clr_r     <= 1'b1;
          end
        H_REF:
          if (tdone)
          begin
            state_r <= H_CLK;
            clr_r   <= 1'b1;
          end
        H_CLK:
          if (tdone)
            state_r <= H_WCAP;
        H_WCAP:
        begin
          wr_r    <= 1'b1;
          addr_r  <= vepms_pkg::REG_CAP;
          wdata_r <= {7'h00, ctrl_r[vepms_pkg::CTL_INV]};
          state_r <= H_WFMT;
        end
        H_WFMT:
        begin
          wr_r    <= 1'b1;
          addr_r  <= vepms_pkg::REG_FMT;
          wdata_r <= {3'h0, ctrl_r[vepms_pkg::CTL_EMB], mode, 2'h0};
          state_r <= mode == vepms_pkg::FSEL_COMPONENT ? H_WPLL : H_WDTR;
          clr_r   <= mode == vepms_pkg::FSEL_COMPONENT;
        end
        H_WPLL:
        begin
          wr_r    <= 1'b1;
          addr_r  <= vepms_pkg::REG_PWR;
          wdata_r <= 8'h01 << vepms_pkg::PLL_BIT;
          state_r <= H_WDTR;
        end
        H_WDTR:
        begin
          wr_r    <= 1'b1;
          addr_r  <= vepms_pkg::REG_DAC;
          wdata_r <= 8'h01 << vepms_pkg::DTR_BIT;
          if (mode == vepms_pkg::FSEL_COMPONENT)
            state_r <= H_WAITPLL;
          else if (ctrl_r[vepms_pkg::CTL_EMB])
            state_r <= H_LOCK;
          else
            state_r <= H_WDAC;
        end
        H_WAITPLL:
          if (tdone)
            state_r <= ctrl_r[vepms_pkg::CTL_EMB] ? H_LOCK : H_WDAC;
        H_LOCK:
        begin
          rd_r   <= 1'b1;
          addr_r <= vepms_pkg::REG_STAT;
          // Read data is only trusted when it answers last cycle's read.
          if (rd_q_r && link.rdata[vepms_pkg::LOCK_BIT])
            state_r <= H_WDAC;
        end
        H_WDAC:
        begin
          wr_r    <= 1'b1;
          addr_r  <= vepms_pkg::REG_DAC;
          wdata_r <= (8'h01 << vepms_pkg::DTR_BIT)
                   | {5'h00, ctrl_r[vepms_pkg::CTL_DAC_LSB +: 3]};
          state_r <= H_RUN;
        end
        H_RUN:
          if (down_r)
            state_r <= H_WDOWN;
        H_WDOWN:
        begin
          wr_r    <= 1'b1;
          addr_r  <= vepms_pkg::REG_DAC;
          wdata_r <= 8'h00;
          state_r <= H_IDLE;
        end
        default:
          state_r <= H_IDLE;
      endcase
      // Sleep drops one cycle after the clearing write has been issued.
      if (state_r == H_IDLE)
        sleep_n_r <= 1'b0;
    end
  end

  assign link.sleep_n = sleep_n_r;
  assign link.pix_clk = pix_clk_r;
  assign link.wr      = wr_r;
  assign link.rd      = rd_r;
  assign link.addr    = addr_r;
  assign link.wdata   = wdata_r;
endmodule // vepms_ctl

// *** logic/vepms_pkg.sv ***
// Shared constants for the video encoder power and mode sequencer pair.
// Assumes a single 50 MHz system clock for both ends.
package vepms_pkg;
  localparam int          CLK_NS        = 20;
  localparam int          ADDR_W        = 6;
  localparam int          DATA_W        = 8;
  // Device register offsets.
  localparam logic [5:0]  REG_PWR       = 6'h06;
  localparam logic [5:0]  REG_FMT       = 6'h0B;
  localparam logic [5:0]  REG_DAC       = 6'h0D;
  localparam logic [5:0]  REG_CAP       = 6'h0E;
  localparam logic [5:0]  REG_STAT      = 6'h0F;
  localparam logic [7:0]  REG_RST_VAL   = 8'h00;
  // Device field positions.
  localparam int          FSEL_LSB      = 2;
  localparam int          EMB_BIT       = 4;
  localparam int          PLL_BIT       = 2;
  localparam int          DTR_BIT       = 4;
  localparam int          DAC_LSB       = 0;
  localparam int          INV_BIT       = 0;
  localparam int          LOCK_BIT      = 0;
  // Function select encodings.
  localparam logic [1:0]  FSEL_COMPOSITE = 2'h0;
  localparam logic [1:0]  FSEL_COMPONENT = 2'h1;
  localparam logic [1:0]  FSEL_HSDAC     = 2'h2;
  // Controller Avalon register byte addresses and fields.
  localparam logic [3:0]  AVS_CTRL      = 4'h0;
  localparam logic [3:0]  AVS_STATUS    = 4'h4;
  localparam int          CTL_GO        = 0;
  localparam int          CTL_DOWN      = 1;
  localparam int          CTL_MODE_LSB  = 2;
  localparam int          CTL_EMB       = 4;
  localparam int          CTL_INV       = 5;
  localparam int          CTL_DAC_LSB   = 8;
  localparam int          ST_RUN        = 0;
  localparam int          ST_BUSY       = 1;
  localparam int          ST_SLEEP      = 2;
  localparam logic [31:0] CTRL_RST_VAL  = 32'h0000_0700;
  // Timing: sleep low time, reference settle, pixel count, PLL settle.
  localparam int          T_SLEEP_NS    = 100;
  localparam int          SLEEP_CYC     = T_SLEEP_NS / CLK_NS + 1;
  localparam int          T_REF_MS      = 10;
  localparam int          REF_CYC       = T_REF_MS * 1000000 / CLK_NS;
  localparam int          INIT_PIX      = 100;
  localparam int          INIT_PIX_CYC  = INIT_PIX + 1;
  localparam int          T_PLL_MS      = 31;
  localparam int          PLL_CYC       = T_PLL_MS * 1000000 / CLK_NS + 1;
  localparam int          FRAME_PIX     = 450450;
endpackage

// *** logic/vepms_link_if.sv ***
// Link between the sequencing controller and the encoder device.
// Assumes both ends share clk; the pixel clock is a level the controller drives.
`timescale 1ns/1ps
interface vepms_link_if;
  logic       sleep_n;  // Chip sleep pin, low puts the device to sleep.
  logic       pix_clk;  // Pixel clock level.
  logic       wr;       // Register write strobe.
  logic       rd;       // Register read request.
  logic [5:0] addr;     // Register offset.
  logic [7:0] wdata;    // Write data.
  logic [7:0] rdata;    // Read data, one cycle after rd.
  modport dev (input sleep_n, pix_clk, wr, rd, addr, wdata, output rdata);
  modport ctl (output sleep_n, pix_clk, wr, rd, addr, wdata, input rdata);
endinterface

// *** logic/vepms_cnt.sv ***
// Saturating event counter with a compare limit.
// Assumes clr and en come from the caller's clock domain.
`timescale 1ns/1ps
module vepms_cnt #(
  parameter int W = 32
) (
  input  wire logic         clk,    // System clock.
  input  wire logic         nrst,   // Asynchronous reset, active low.
  input  wire logic         clr,    // Restart the count.
  input  wire logic         en,     // Count one event.
  input  wire logic [W-1:0] limit,  // Events needed for done.
  output logic              done    // Limit reached since last clear.
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= '0;
    else if (clr)
      cnt_r <= '0;
    else if (en && cnt_r != {W{1'b1}})
      cnt_r <= cnt_r + 1'b1;
  end

  // Done is masked during clear so a stale count never leaks into a new wait.
  assign done = !clr && (cnt_r >= limit);
endmodule // vepms_cnt

// *** logic/vepms_dev.sv ***
// Encoder device end: register file, sleep handling, mode power and capture.
// Assumes link inputs are synchronous to clk and pix_clk is a sampled level.
`timescale 1ns/1ps
module vepms_dev #(
  parameter int FRAME_PIX = vepms_pkg::FRAME_PIX
) (
  input  wire logic  clk,             // System clock.
  input  wire logic  nrst,            // Asynchronous reset, active low.
  vepms_link_if.dev  link,            // Link to the controller.
  input  wire logic [7:0] pix_in,     // Pixel bus input.
  input  wire logic  hsync_input,     // Horizontal sync input.
  input  wire logic  vsync_input,     // Vertical sync input.
  output logic [7:0] pix_q,           // Captured pixel data.
  output logic       hsync_q,         // Captured horizontal sync.
  output logic       vsync_q,         // Captured vertical sync.
  output logic       dp_run,          // Datapath out of reset.
  output logic [1:0] function_select_field, // Active function.
  output logic       composite_pwr,   // Composite block powered.
  output logic       component_pwr,   // Component block powered.
  output logic       hsdac_pwr,       // High-speed DAC path powered.
  output logic       pll_pwr,         // PLL powered.
  output logic [2:0] dac_drive,       // DAC channels driving.
  output logic       locked           // Embedded sync lock.
);
  logic [7:0] fmt_r, pwr_r, dac_r, cap_r, rdata_r;
  logic       pclk_q_r, dp_run_r, locked_r, lock_done;
  logic       pix_rise, pix_fall, sample_en;
  logic [1:0] fsel;

  assign fsel      = fmt_r[vepms_pkg::FSEL_LSB +: 2];
  assign pix_rise  = link.pix_clk && !pclk_q_r;
  assign pix_fall  = !link.pix_clk && pclk_q_r;
  assign sample_en = cap_r[vepms_pkg::INV_BIT] ? pix_fall : pix_rise;

  // Writes need no pixel clock; sleep clears every register.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fmt_r <= vepms_pkg::REG_RST_VAL;
      pwr_r <= vepms_pkg::REG_RST_VAL;
      dac_r <= vepms_pkg::REG_RST_VAL;
      cap_r <= vepms_pkg::REG_RST_VAL;
    end
    else if (!link.sleep_n)
    begin
      fmt_r <= vepms_pkg::REG_RST_VAL;
      pwr_r <= vepms_pkg::REG_RST_VAL;
      dac_r <= vepms_pkg::REG_RST_VAL;
      cap_r <= vepms_pkg::REG_RST_VAL;
    end
    else if (link.wr)
    begin
      if (link.addr == vepms_pkg::REG_FMT)
        fmt_r <= link.wdata;
      else if (link.addr == vepms_pkg::REG_PWR)
        pwr_r <= link.wdata;
      else if (link.addr == vepms_pkg::REG_DAC)
        dac_r <= link.wdata;
      else if (link.addr == vepms_pkg::REG_CAP)
        cap_r <= link.wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= '0;
    else if (link.rd)
    begin
      if (link.addr == vepms_pkg::REG_FMT)
        rdata_r <= fmt_r;
      else if (link.addr == vepms_pkg::REG_PWR)
        rdata_r <= pwr_r;
      else if (link.addr == vepms_pkg::REG_DAC)
        rdata_r <= dac_r;
      else if (link.addr == vepms_pkg::REG_CAP)
        rdata_r <= cap_r;
      else if (link.addr == vepms_pkg::REG_STAT)
        rdata_r <= {7'h00, locked_r};
      else
        rdata_r <= 8'h00;
    end
  end
  assign link.rdata = rdata_r;

  // Datapath leaves reset only on a pixel clock edge after the bit is set.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pclk_q_r <= 1'b0;
      dp_run_r <= 1'b0;
    end
    else
    begin
      pclk_q_r <= link.pix_clk;
      if (!dac_r[vepms_pkg::DTR_BIT])
        dp_run_r <= 1'b0;
      else if (pix_rise)
        dp_run_r <= 1'b1;
    end
  end

  // Lock takes a full frame of pixel clocks after datapath release.
  vepms_cnt #(.W(32)) u_lock (
    .clk   (clk),
    .nrst  (nrst),
    .clr   (!(fmt_r[vepms_pkg::EMB_BIT] && dp_run_r)),
    .en    (pix_rise),
    .limit (32'(FRAME_PIX + 1)),
    .done  (lock_done)
  );

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      locked_r              <= 1'b0;
      function_select_field <= vepms_pkg::FSEL_COMPOSITE;
      composite_pwr         <= 1'b0;
      component_pwr         <= 1'b0;
      hsdac_pwr             <= 1'b0;
      pll_pwr               <= 1'b0;
      dac_drive             <= 3'h0;
      dp_run                <= 1'b0;
    end
    else
    begin
      locked_r              <= lock_done;
      function_select_field <= fsel;
      composite_pwr         <= link.sleep_n && fsel == vepms_pkg::FSEL_COMPOSITE;
      component_pwr         <= link.sleep_n && fsel == vepms_pkg::FSEL_COMPONENT;
      hsdac_pwr             <= link.sleep_n && fsel == vepms_pkg::FSEL_HSDAC;
      pll_pwr               <= link.sleep_n && pwr_r[vepms_pkg::PLL_BIT];
      dac_drive             <= link.sleep_n ? dac_r[vepms_pkg::DAC_LSB +: 3] : 3'h0;
      dp_run                <= dp_run_r;
    end
  end
  assign locked = locked_r;

  // Captured inputs read zero while the datapath is held in reset.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pix_q   <= 8'h00;
      hsync_q <= 1'b0;
      vsync_q <= 1'b0;
    end
    else if (!dp_run_r)
    begin
      pix_q   <= 8'h00;
      hsync_q <= 1'b0;
      vsync_q <= 1'b0;
    end
    else if (sample_en)
    begin
      pix_q   <= pix_in;
      hsync_q <= hsync_input;
      vsync_q <= vsync_input;
    end
  end
endmodule // vepms_dev

// *** dv/vepms_props.sv ***
// Checker for the link between the sequencing controller and the encoder device.
// Assumes it sits beside the link interface and gets the same shortened waits.
`timescale 1ns/1ps
module vepms_props #(
  parameter int REF_CYC = vepms_pkg::REF_CYC,
  parameter int PLL_CYC = vepms_pkg::PLL_CYC
) (
  input wire logic       clk,     // System clock.
  input wire logic       nrst,    // Asynchronous reset, active low.
  input wire logic       sleep_n, // Sleep pin.
  input wire logic       pix_clk, // Pixel clock level.
  input wire logic       wr,      // Write strobe.
  input wire logic       rd,      // Read request.
  input wire logic [5:0] addr,    // Register offset.
  input wire logic [7:0] wdata,   // Write data.
  input wire logic [7:0] rdata    // Read data.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [31:0] low_cnt, up_cnt, pix_cnt, pll_cnt;
  logic [1:0]  fsel_r;
  logic        pix_d, fmt_w, dtr_r, pll_r, emb_r, stat_rd, lock_r;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      low_cnt <= 32'h0;
    else
      low_cnt <= sleep_n ? 32'h0 : low_cnt + 32'h1;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      up_cnt <= 32'h0;
    else
      up_cnt <= sleep_n ? up_cnt + 32'h1 : 32'h0;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      pll_cnt <= 32'h0;
    else
      pll_cnt <= (wr && addr == vepms_pkg::REG_PWR) ? 32'h0 : pll_cnt + 32'h1;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      {pix_d, pix_cnt} <= 33'h0;
    else
    begin
      pix_d <= pix_clk;
      pix_cnt <= sleep_n ? pix_cnt + 32'(pix_clk && !pix_d) : 32'h0;
    end
  // Shadow of the device registers; sleep wipes it just as it wipes the device.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      {fsel_r, fmt_w, dtr_r, pll_r, emb_r, stat_rd, lock_r} <= 8'h0;
    else if (!sleep_n)
      {fsel_r, fmt_w, dtr_r, pll_r, emb_r, stat_rd, lock_r} <= 8'h0;
    else
    begin
      stat_rd <= rd && addr == vepms_pkg::REG_STAT;
      lock_r <= lock_r || (stat_rd && rdata[vepms_pkg::LOCK_BIT]);
      if (wr && addr == vepms_pkg::REG_FMT)
      begin
        fsel_r <= wdata[vepms_pkg::FSEL_LSB +: 2];
        emb_r <= wdata[vepms_pkg::EMB_BIT];
        fmt_w <= 1'h1;
      end
      if (wr && addr == vepms_pkg::REG_PWR)
        pll_r <= wdata[vepms_pkg::PLL_BIT];
      if (wr && addr == vepms_pkg::REG_DAC)
        dtr_r <= wdata[vepms_pkg::DTR_BIT];
    end
  sequence fmt_wr_s; wr && addr == vepms_pkg::REG_FMT; endsequence
  sequence pll_on_s; wr && addr == vepms_pkg::REG_PWR && wdata[vepms_pkg::PLL_BIT]; endsequence
  sequence dtr_on_s; wr && addr == vepms_pkg::REG_DAC && wdata[vepms_pkg::DTR_BIT]; endsequence
  sequence dac_on_s; wr && addr == vepms_pkg::REG_DAC && wdata[2:0] != 3'h0; endsequence
  sleep_low_a: assert property ($rose(sleep_n) |-> low_cnt >= vepms_pkg::SLEEP_CYC)
    else $error("sleep pin released too early");
  ref_settle_a: assert property ((wr || $rose(pix_clk)) && sleep_n |-> up_cnt + 1 >= REF_CYC)
    else $error("link used before references settled");
  pix_init_a: assert property (fmt_wr_s |-> pix_cnt >= vepms_pkg::INIT_PIX)
    else $error("function select written too soon");
  dtr_init_a: assert property (dtr_on_s |-> pix_cnt > vepms_pkg::INIT_PIX)
    else $error("datapath released too soon");
  dtr_order_a: assert property (dtr_on_s |-> fmt_w)
    else $error("datapath released before mode chosen");
  pll_order_a: assert property (pll_on_s |-> fsel_r == vepms_pkg::FSEL_COMPONENT)
    else $error("pll started outside component mode");
  pll_settle_a: assert property (dac_on_s |-> !pll_r || pll_cnt + 1 >= PLL_CYC)
    else $error("outputs on before pll settled");
  emb_lock_a: assert property (dac_on_s |-> !emb_r || lock_r)
    else $error("outputs on before lock seen");
  dtr_clear_a: assert property ($fell(sleep_n) |-> !dtr_r)
    else $error("sleep entered with datapath running");
  wr_awake_a: assert property (wr |-> sleep_n)
    else $error("write sent while device asleep");
endmodule // vepms_props

// *** dv/vepms_tb_top.sv ***
// Self-checking bench: controller and device joined over the link interface.
// Assumes shortened waits so every mode comes up within a few hundred cycles.
`timescale 1ns/1ps
module vepms_tb_top;
  localparam int REF = 20;
  localparam int PLL = 30;
  logic        clk = 1'h0;
  logic        nrst = 1'h0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd_val;
  logic        avs_waitrequest, hsync_q, vsync_q, dp_run, locked;
  logic        hsync_input = 1'h0;
  logic        vsync_input = 1'h0;
  logic        composite_pwr, component_pwr, hsdac_pwr, pll_pwr;
  logic [7:0]  pix_in = 8'h0;
  logic [7:0]  pix_q;
  logic [1:0]  fsel;
  logic [2:0]  dac_drive;
  logic [63:0] note;
  logic [63:0] notes[$];
  int          errors = 0;
  int          num_checks = 0;
  always #10 clk = ~clk;
  vepms_link_if vepms_link_if_i ();
  vepms_ctl #(.REF_CYC(REF), .PLL_CYC(PLL), .PIX_HALF(1)) vepms_ctl_i (.clk(clk), .nrst(nrst),
    .link(vepms_link_if_i.ctl), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  vepms_dev #(.FRAME_PIX(10)) vepms_dev_i (.clk(clk), .nrst(nrst), .link(vepms_link_if_i.dev),
    .pix_in(pix_in), .hsync_input(hsync_input), .vsync_input(vsync_input), .pix_q(pix_q),
    .hsync_q(hsync_q), .vsync_q(vsync_q), .dp_run(dp_run), .function_select_field(fsel),
    .composite_pwr(composite_pwr), .component_pwr(component_pwr), .hsdac_pwr(hsdac_pwr),
    .pll_pwr(pll_pwr), .dac_drive(dac_drive), .locked(locked));
  vepms_props #(.REF_CYC(REF), .PLL_CYC(PLL)) vepms_props_i (.clk(clk), .nrst(nrst),
    .sleep_n(vepms_link_if_i.sleep_n), .pix_clk(vepms_link_if_i.pix_clk),
    .wr(vepms_link_if_i.wr), .rd(vepms_link_if_i.rd), .addr(vepms_link_if_i.addr),
    .wdata(vepms_link_if_i.wdata), .rdata(vepms_link_if_i.rdata));
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_rd(input logic [31:0] e, input logic [31:0] g);
    compare("read data", e, g);
  endtask
  task automatic check_dev(input logic [20:0] e);
    compare("device state", 32'(e), 32'({fsel, composite_pwr, component_pwr, hsdac_pwr,
      pll_pwr, dac_drive, dp_run, locked, pix_q, hsync_q, vsync_q}));
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Called just after a rising edge; the request stands until waitrequest is seen low.
  task automatic bus(input bit is_wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [63:0] n_exp);
    int n;
    n = 0;
    if (!is_wr)
      notes.push_back(n_exp);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= is_wr;
    avs_read <= !is_wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 50);
    rd_val = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (n >= 50)
    begin
      errors++;
      conclude();
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, {m, e & m});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 64'h0);
  endtask
  task automatic wait_st(input logic [2:0] v);
    int n;
    n = 0;
    do
    begin
      rd(vepms_pkg::AVS_STATUS, 32'h0, 32'h0);
      n++;
    end
    while (rd_val[2:0] !== v && n < 400);
    if (n >= 400)
    begin
      errors++;
      conclude();
    end
  endtask
  // A read note with an empty mask is a poll whose value is not judged.
  always @(posedge clk)
    if (avs_read && avs_waitrequest === 1'h0 && notes.size() > 0)
    begin
      note = notes.pop_front();
      if (note[63:32] != 32'h0)
        check_rd(note[31:0], avs_readdata & note[63:32]);
    end
  always @(posedge clk)
  begin
    pix_in <= 8'($urandom);
    hsync_input <= 1'($urandom);
    vsync_input <= 1'($urandom);
  end
  initial
  begin
    logic [2:0] mask;
    logic       emb;
    logic       inv, cap_ok;
    logic [9:0] cap;
    void'($urandom(14299));
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rd(vepms_pkg::AVS_CTRL, 32'hFFFF_FFFF, vepms_pkg::CTRL_RST_VAL);
    rd(4'h8, 32'hFFFF_FFFF, 32'h0);
    check_dev(21'h0);
    for (int m = 0; m < 4; m++)
    begin
      mask = 3'($urandom_range(1, 7));
      emb = (m == 0);
      inv = 1'($urandom);
      wr(vepms_pkg::AVS_CTRL, {21'h0, mask, 2'h0, inv, emb, 2'(m), 2'h1});
      wait_st(3'h1);
      compare("device state", 32'h0, 32'(1'(m == 0) + 1'(m == 1) + 1'(m == 2)) -
        32'(composite_pwr + component_pwr + hsdac_pwr));
      compare("modes", {22'h0, 2'(m), 1'(m == 0), 1'(m == 1), 1'(m == 2), 1'(m == 1), mask},
        {22'h0, fsel, composite_pwr, component_pwr, hsdac_pwr, pll_pwr, dac_drive});
      compare("datapath", {30'h0, 1'h1, emb}, {30'h0, dp_run, locked});
      // Capture happens where the pixel clock leaves the level named by inv.
      cap_ok = 1'b0;
      for (int k = 0; k < 8 && !cap_ok; k++)
      begin
        @(posedge clk);
        cap_ok = (vepms_link_if_i.pix_clk === inv);
      end
      @(posedge clk);
      cap = {pix_in, hsync_input, vsync_input};
      @(posedge clk);
      compare("capture", {22'h0, cap}, {22'h0, pix_q, hsync_q, vsync_q});
      wr(vepms_pkg::AVS_CTRL, 32'h1);
      rd(vepms_pkg::AVS_STATUS, 32'h3, 32'h1);
      wr(vepms_pkg::AVS_CTRL, 32'h2);
      wait_st(3'h4);
      check_dev(21'h0);
      wr(vepms_pkg::AVS_CTRL, 32'h2);
      rd(vepms_pkg::AVS_STATUS, 32'h3, 32'h0);
    end
    wr(vepms_pkg::AVS_CTRL, 32'h0000_0705);
    repeat (60) @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    compare("sleep pin", 32'h0, 32'(vepms_link_if_i.sleep_n));
    rd(vepms_pkg::AVS_CTRL, 32'hFFFF_FFFF, vepms_pkg::CTRL_RST_VAL);
    check_dev(21'h0);
    conclude();
  end
endmodule // vepms_tb_top
